/* design/spm_fifo.sv */
`timescale 1ns/1ps
`default_nettype none
module spm_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  input  wire logic  clk,
  input  wire logic  rst_n,
  spm_stream_if.snk  wr,
  spm_stream_if.src  rd
);
  localparam int AW = $clog2(D);

  logic [W-1:0]  mem [D];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0]   cnt_r;
  logic [W-1:0]  data_r;
  logic          ov_r;
  logic          push;
  logic          load;
  logic          from_mem;
  logic          bypass;

  // =====================================================
  // handshakes
  assign wr.ready = (cnt_r != (AW+1)'(D));
  assign rd.valid = ov_r;
  assign rd.data  = data_r;
  assign push     = wr.valid & wr.ready;
  assign load     = ~ov_r | rd.ready;
  assign from_mem = load & (cnt_r != '0);
  assign bypass   = load & (cnt_r == '0) & push;

  // =====================================================
  // storage and output stage
  always_ff @(posedge clk) begin
    if (push && !bypass) begin
      mem[wp_r] <= wr.data;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wp_r   <= '0;
      rp_r   <= '0;
      cnt_r  <= '0;
      ov_r   <= 1'b0;
      data_r <= '0;
    end else begin
      if (push && !bypass) begin
        wp_r <= AW'(wp_r + 1'b1);
      end
      if (from_mem) begin
        rp_r   <= AW'(rp_r + 1'b1);
        data_r <= mem[rp_r];
        ov_r   <= 1'b1;
      end else if (bypass) begin
        data_r <= wr.data;
        ov_r   <= 1'b1;
      end else if (load) begin
        ov_r <= 1'b0;
      end
      cnt_r <= (AW+1)'(cnt_r + {{AW{1'b0}}, push & ~bypass}
               - {{AW{1'b0}}, from_mem});
    end
  end

  property p_fifo_bound;
    @(posedge clk) disable iff (!rst_n)
      (cnt_r == (AW+1)'(D)) |-> !wr.ready;
  endproperty
  a_fifo_bound: assert property (p_fifo_bound)
    else $error("fifo accepts write while full");
endmodule
`default_nettype wire

/* design/spm_master.sv */
`timescale 1ns/1ps
`default_nettype none
module spm_master #(
  parameter int FIFO_DEPTH = spm_pkg::SPM_FIFO_DEPTH
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [7:0] sfr_addr,
  input  wire logic       sfr_wr,
  input  wire logic       sfr_rd,
  input  wire logic [7:0] sfr_wdata,
  output logic      [7:0] sfr_rdata,
  output logic            irq,
  output logic            tx_room,
  input  wire logic       serial_in_line,
  output logic            serial_out_line,
  output logic            serial_shift_clock,
  output logic            target_select_out_n
);
  import spm_pkg::*;

  // =====================================================
  // declarations
  logic [7:0] serial_control_reg_r;
  logic [7:0] serial_irq_enable_reg_r;
  logic [7:0] serial_divider_reg_r;
  logic [7:0] rx_holding_byte_r;
  logic       rx_full_r;
  logic [3:0] flags_r;
  logic [3:0] flags_nxt;
  logic [3:0] flag_set;
  logic [7:0] rdata_r;
  logic       irq_r;
  logic       tx_room_r;
  logic [7:0] shreg_r;
  logic [3:0] bitcnt_r;
  logic       phase_r;
  logic       sclk_r;
  logic       mosi_r;
  logic       sel_n_r;
  spm_state_t st_r;
  logic       tick;
  logic       te, re, en, lsb, cpol, go;
  logic       stat_rd, rdr_rd, done, start, out_bit;
  logic [7:0] shifted;
  logic [7:0] stat_val;

  spm_stream_if #(.W(SPM_BITS)) tx_in ();
  spm_stream_if #(.W(SPM_BITS)) tx_out ();
  assign te   = serial_control_reg_r[SPM_C0_TE];
  assign re   = serial_control_reg_r[SPM_C0_RE];
  assign en   = serial_control_reg_r[SPM_C0_EN];
  assign lsb  = serial_control_reg_r[SPM_C0_LSB];
  assign cpol = serial_control_reg_r[SPM_C0_CPOL];
  assign go   = en & te;
  assign stat_rd = sfr_rd & (sfr_addr == SPM_ADDR_STAT);
  assign rdr_rd  = sfr_rd & (sfr_addr == SPM_ADDR_RDR);

  // =====================================================
  // transmit holding fifo
  // holding byte is write only
  assign tx_in.valid = sfr_wr & (sfr_addr == SPM_ADDR_TDR);
  assign tx_in.data  = sfr_wdata;

  spm_fifo #(.W(SPM_BITS), .D(FIFO_DEPTH)) u_fifo (
    .clk   (clk),
    .rst_n (rst_n),
    .wr    (tx_in),
    .rd    (tx_out)
  );

  // byte leaves holding when idle and enabled
  assign start        = (st_r == SPM_ST_IDLE) & go & tx_out.valid;
  assign tx_out.ready = start;
  // half period ticks from the peripheral clock
  // divisor taken from the selected bits
  spm_tick u_tick (
    .clk     (clk),
    .rst_n   (rst_n),
    .run     (st_r != SPM_ST_IDLE),
    .divisor (serial_divider_reg_r),
    .tick    (tick)
  );

  // =====================================================
  // register writes
  // every register back to reset value
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      serial_control_reg_r    <= SPM_RST_CON0;
      serial_irq_enable_reg_r <= SPM_RST_CON1;
      serial_divider_reg_r    <= SPM_RST_CLKD;
    end else if (sfr_wr) begin
      if (sfr_addr == SPM_ADDR_CON0) begin
        serial_control_reg_r <= sfr_wdata & SPM_MASK_CON0;
      end
      if (sfr_addr == SPM_ADDR_CON1) begin
        serial_irq_enable_reg_r <= sfr_wdata & SPM_MASK_CON1;
      end
      if (sfr_addr == SPM_ADDR_CLKD) begin
        serial_divider_reg_r <= sfr_wdata & SPM_MASK_CLKD;
      end
    end
  end

  // =====================================================
  // shift engine
  // bit order for both directions
  assign out_bit = lsb ? shreg_r[0] : shreg_r[SPM_BITS-1];
  assign shifted = lsb ? {serial_in_line, shreg_r[7:1]}
                       : {shreg_r[6:0], serial_in_line};
  assign done    = (st_r == SPM_ST_SHIFT) & tick & phase_r
                   & (bitcnt_r == SPM_LAST_BIT);
  // drives the clock, never watches for another master
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_r     <= SPM_ST_IDLE;
      shreg_r  <= 8'h00;
      bitcnt_r <= 4'h0;
      phase_r  <= 1'b0;
      sclk_r   <= 1'b0;
      mosi_r   <= 1'b0;
      sel_n_r  <= 1'b1;
    end else if (!go) begin
      // disabled holds clock at idle level
      st_r    <= SPM_ST_IDLE;
      sclk_r  <= cpol;
      sel_n_r <= 1'b1;
      phase_r <= 1'b0;
    end else begin
      unique case (st_r)
        SPM_ST_IDLE: begin
          sclk_r <= cpol;
          if (start) begin
            shreg_r  <= tx_out.data;
            bitcnt_r <= 4'h0;
            phase_r  <= 1'b0;
            // select falls ahead of first bit
            sel_n_r  <= ~serial_control_reg_r[SPM_C0_SSEL];
            st_r     <= SPM_ST_LEAD;
          end
        end
        SPM_ST_LEAD: begin
          if (tick) begin
            st_r <= SPM_ST_SHIFT;
          end
        end
        SPM_ST_SHIFT: begin
          if (tick && !phase_r) begin
            // first edge of the period launches
            sclk_r  <= ~sclk_r;
            mosi_r  <= out_bit;
            phase_r <= 1'b1;
          end else if (tick) begin
            sclk_r   <= ~sclk_r;
            shreg_r  <= shifted;
            phase_r  <= 1'b0;
            bitcnt_r <= 4'(bitcnt_r + 4'h1);
            if (bitcnt_r == SPM_LAST_BIT) begin
              st_r <= SPM_ST_TRAIL;
            end
          end
        end
        SPM_ST_TRAIL: begin
          if (tick) begin
            sel_n_r <= 1'b1;
            st_r    <= SPM_ST_IDLE;
          end
        end
      endcase
    end
  end

  // =====================================================
  // receive holding and flags
  // received byte held while next shifts
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rx_holding_byte_r <= 8'h00;
      rx_full_r         <= 1'b0;
    end else begin
      if (done && re) begin
        rx_holding_byte_r <= shifted;
        rx_full_r         <= 1'b1;
      end else if (rdr_rd) begin
        rx_full_r <= 1'b0;
      end
    end
  end

  always_comb begin
    flag_set             = 4'h0;
    flag_set[SPM_F_ROVR] = done & re & rx_full_r;
    flag_set[SPM_F_RFUL] = done & re;
    flag_set[SPM_F_TEMP] = start;
    flag_set[SPM_F_TEND] = (st_r == SPM_ST_TRAIL) & tick & go
                           & ~tx_out.valid;
    // status read clears, new event wins
    flags_nxt = (stat_rd ? 4'h0 : flags_r) | flag_set;
  end

  assign stat_val = {3'h0, st_r != SPM_ST_IDLE, flags_r};
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      flags_r   <= SPM_RST_FLAGS;
      irq_r     <= 1'b0;
      tx_room_r <= 1'b1;
    end else begin
      flags_r   <= flags_nxt;
      irq_r     <= |(flags_nxt & serial_irq_enable_reg_r[3:0]);
      tx_room_r <= tx_in.ready;
    end
  end

  // =====================================================
  // register reads
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata_r <= 8'h00;
    end else if (sfr_rd) begin
      unique case (sfr_addr)
        SPM_ADDR_CON0: rdata_r <= serial_control_reg_r;
        SPM_ADDR_CON1: rdata_r <= serial_irq_enable_reg_r;
        SPM_ADDR_CLKD: rdata_r <= serial_divider_reg_r;
        SPM_ADDR_STAT: rdata_r <= stat_val;
        SPM_ADDR_RDR:  rdata_r <= rx_holding_byte_r;
        default:       rdata_r <= 8'h00;
      endcase
    end
  end

  assign sfr_rdata           = rdata_r;
  assign irq                 = irq_r;
  assign tx_room             = tx_room_r;
  assign serial_out_line     = mosi_r;
  assign serial_shift_clock  = sclk_r;
  assign target_select_out_n = sel_n_r;

  // =====================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_clk_quiet;
    (st_r == SPM_ST_IDLE) && $past(st_r == SPM_ST_IDLE) && $stable(cpol)
      |=> $stable(sclk_r);
  endproperty
  a_clk_quiet: assert property (p_clk_quiet)
    else $error("serial clock toggles while idle");
  property p_te_stop;
    !go |=> (st_r == SPM_ST_IDLE) && (sclk_r == $past(cpol));
  endproperty
  a_te_stop: assert property (p_te_stop)
    else $error("transfer continues after disable");
  property p_launch_edge;
    $changed(mosi_r) |-> $changed(sclk_r) && (sclk_r != cpol);
  endproperty
  a_launch_edge: assert property (p_launch_edge)
    else $error("output bit moved off the launch edge");
  property p_eight;
    (st_r == SPM_ST_SHIFT) && tick && phase_r && (bitcnt_r == SPM_LAST_BIT)
      |=> (st_r == SPM_ST_TRAIL) && (bitcnt_r == 4'h8);
  endproperty
  a_eight: assert property (p_eight)
    else $error("byte did not end after eight bits");
  property p_stat_clear;
    stat_rd |=> (flags_r == $past(flag_set));
  endproperty
  a_stat_clear: assert property (p_stat_clear)
    else $error("status read did not clear flags");
  property p_overrun;
    done && re && rx_full_r |=> flags_r[SPM_F_ROVR] && rx_full_r;
  endproperty
  a_overrun: assert property (p_overrun)
    else $error("overrun not flagged");
  property p_sel_off;
    !serial_control_reg_r[SPM_C0_SSEL] && (st_r == SPM_ST_IDLE)
      |=> ##[0:1] sel_n_r;
  endproperty
  a_sel_off: assert property (p_sel_off)
    else $error("select low with auto select cleared");
  property p_div_reset;
    @(posedge clk) disable iff (1'b0)
      !rst_n |=> (serial_divider_reg_r == SPM_RST_CLKD);
  endproperty
  a_div_reset: assert property (p_div_reset)
    else $error("divider not four after reset");
  property p_rx_read;
    rdr_rd |=> (sfr_rdata == $past(rx_holding_byte_r));
  endproperty
  a_rx_read: assert property (p_rx_read)
    else $error("receive holding read wrong");
  property p_irq;
    ((flags_r & serial_irq_enable_reg_r[3:0]) != 4'h0) && !stat_rd
      && $stable(serial_irq_enable_reg_r) |-> irq_r;
  endproperty
  a_irq: assert property (p_irq)
    else $error("enabled flag without interrupt");
endmodule
`default_nettype wire

/* design/spm_pkg.sv */
package spm_pkg;
  // register addresses on the special function bus
  localparam logic [7:0] SPM_ADDR_CLKD  = 8'hd2;
  localparam logic [7:0] SPM_ADDR_STAT  = 8'hd3;
  localparam logic [7:0] SPM_ADDR_TDR   = 8'hd4;
  localparam logic [7:0] SPM_ADDR_RDR   = 8'hd5;
  localparam logic [7:0] SPM_ADDR_CON0  = 8'hd6;
  localparam logic [7:0] SPM_ADDR_CON1  = 8'hd7;
  // reset values
  localparam logic [7:0] SPM_RST_CON0   = 8'h00;
  localparam logic [7:0] SPM_RST_CON1   = 8'h00;
  localparam logic [7:0] SPM_RST_CLKD   = 8'h04;
  localparam logic [3:0] SPM_RST_FLAGS  = 4'h2;
  // writable masks
  localparam logic [7:0] SPM_MASK_CON0  = 8'h7e;
  localparam logic [7:0] SPM_MASK_CON1  = 8'h0f;
  localparam logic [7:0] SPM_MASK_CLKD  = 8'hfc;
  // control register 0 fields
  localparam int SPM_C0_TE   = 6;
  localparam int SPM_C0_RE   = 5;
  localparam int SPM_C0_EN   = 4;
  localparam int SPM_C0_SSEL = 3;
  localparam int SPM_C0_LSB  = 2;
  localparam int SPM_C0_CPOL = 1;
  // status flag fields
  localparam int SPM_F_TEND  = 3;
  localparam int SPM_F_ROVR  = 2;
  localparam int SPM_F_TEMP  = 1;
  localparam int SPM_F_RFUL  = 0;
  localparam int SPM_BUSY    = 4;
  // byte framing
  localparam int SPM_BITS    = 8;
  localparam logic [3:0] SPM_LAST_BIT = 4'h7;
  localparam int SPM_FIFO_DEPTH = 8;

  typedef enum logic [3:0] {
    SPM_ST_IDLE  = 4'b0001,
    SPM_ST_LEAD  = 4'b0010,
    SPM_ST_SHIFT = 4'b0100,
    SPM_ST_TRAIL = 4'b1000
  } spm_state_t;
endpackage

/* design/spm_stream_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface spm_stream_if #(
  parameter int W = 8
);
  logic [W-1:0] data;
  logic         valid;
  logic         ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface
`default_nettype wire

/* design/spm_tick.sv */
`timescale 1ns/1ps
`default_nettype none
module spm_tick (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       run,
  input  wire logic [7:0] divisor,
  output logic            tick
);
  logic [6:0] cnt_r;
  logic [6:0] half;

  // half a serial period; an empty divider falls back to four
  assign half = (divisor[7:2] == 6'h00) ? 7'h02 : divisor[7:1];
  assign tick = run & (cnt_r == 7'(half - 7'h01));

  always_ff @(posedge clk) begin
    if (!rst_n || !run || tick) begin
      cnt_r <= 7'h00;
    end else begin
      cnt_r <= 7'(cnt_r + 7'h01);
    end
  end
endmodule
`default_nettype wire

/* sim/spm_slave_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ====================
// serial target, selected by low select
module spm_slave_model (
  input  wire logic sclk,
  input  wire logic mosi,
  input  wire logic sel_n,
  input  wire logic cpol,
  input  wire logic lsb,
  output var  logic miso,
  output var  int   nbytes
);
  logic [3:0] idx;
  logic [2:0] b;
  logic [7:0] cur;
  logic [7:0] got;
  logic [7:0] got_q[$];

  initial begin
    miso = 1'b0;
    nbytes = 0;
    idx = 4'h0;
  end

  always @(negedge sel_n) begin
    idx = 4'h0;
    cur = 8'ha5 ^ 8'(nbytes * 59);
  end

  always @(posedge sel_n) begin
    if (idx == 4'h8) begin
      got_q.push_back(got);
      nbytes++;
    end
    miso = ~miso;
  end

  always @(sclk) begin
    if (!sel_n && idx < 4'h8) begin
      b = lsb ? idx[2:0] : 3'h7 - idx[2:0];
      if (sclk !== cpol) begin
        miso = cur[b];
      end else begin
        got[b] = mosi;
        idx = idx + 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

/* sim/test_spm_master.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin \
  num_checks++; \
  if ((a) !== (b)) begin \
    miscompares++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (b)); \
  end \
end
// ====================
// bench top
module test_spm_master;
  import spm_pkg::*;
  logic       clk, rst_n, sfr_wr, sfr_rd, irq, tx_room;
  logic       sdo, sck, sel_n, sdi, cpol, lsb, sck_q;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, div;
  logic [7:0] sent[$];
  int         seed, miscompares, num_checks, nbytes, nb;
  int         edges, first_t, last_t, cyc;

  spm_master #(.FIFO_DEPTH(SPM_FIFO_DEPTH)) u_dut (
    .clk(clk), .rst_n(rst_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .irq(irq), .tx_room(tx_room), .serial_in_line(sdi),
    .serial_out_line(sdo), .serial_shift_clock(sck),
    .target_select_out_n(sel_n)
  );
  spm_slave_model u_slv (
    .sclk(sck), .mosi(sdo), .sel_n(sel_n), .cpol(cpol), .lsb(lsb),
    .miso(sdi), .nbytes(nbytes)
  );

  // ====================
  // helpers
  function automatic logic [7:0] reply(input int k);
    return 8'ha5 ^ 8'(k * 59);
  endfunction
  function automatic int half(input logic [7:0] d);
    return (d[7:2] == 6'h00) ? 2 : int'(d[7:2]) * 2;
  endfunction
  task automatic stop_test();
    $display("checks=%0d miscompares=%0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge clk);
    sfr_wr = 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(negedge clk);
    sfr_rd = 1'b0;
    `CHK(sfr_rdata, e)
  endtask
  task automatic wait_bytes(input int n);
    for (int i = 0; i < 40000 && nbytes < n; i++) @(negedge clk);
    if (nbytes < n) begin
      miscompares++;
      stop_test();
    end
  endtask

  // edge counter while selected
  always @(posedge clk) begin
    cyc++;
    sck_q <= sck;
    if (!sel_n && sck_q !== sck) begin
      if (edges == 0) first_t = cyc;
      last_t = cyc;
      edges++;
    end
  end

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ====================
  // main sequence
  initial begin
    seed = 32'h9efa;
    {rst_n, sfr_wr, sfr_rd, cpol, lsb} = 5'h00;
    {sfr_addr, sfr_wdata} = 16'h0000;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    rd_chk(SPM_ADDR_CLKD, SPM_RST_CLKD);
    rd_chk(SPM_ADDR_STAT, 8'h02);
    rd_chk(SPM_ADDR_CON0, SPM_RST_CON0);
    rd_chk(SPM_ADDR_CON1, SPM_RST_CON1);
    rd_chk(SPM_ADDR_TDR, 8'h00);
    rd_chk(8'hc0, 8'h00);
    `CHK(sck, 1'b0)
    `CHK(sel_n, 1'b1)
    // every polarity and order, corner dividers
    for (int m = 0; m < 4; m++) begin
      div = (8'($random(seed)) & 8'h3c) | 8'h04;
      if (m == 0) div = 8'h04;
      if (m == 3) div = 8'hfc;
      cpol = m[0];
      lsb = m[1];
      wr(SPM_ADDR_CLKD, div);
      wr(SPM_ADDR_CON0, 8'h78 | {5'h00, lsb, cpol, 1'b0});
      sent.delete();
      sent.push_back(8'($random(seed)));
      edges = 0;
      nb = nbytes;
      wr(SPM_ADDR_TDR, sent[0]);
      wait_bytes(nb + 1);
      `CHK(u_slv.got_q[nb], sent[0])
      rd_chk(SPM_ADDR_RDR, reply(nb));
      `CHK(edges, 16)
      `CHK(last_t - first_t, 15 * half(div))
      `CHK(sck, cpol)
      rd_chk(SPM_ADDR_STAT, 8'h0b);
    end
    // back to back with overrun and interrupt
    cpol = 1'b0;
    lsb = 1'b0;
    wr(SPM_ADDR_CLKD, 8'h08);
    wr(SPM_ADDR_CON0, 8'h78);
    wr(SPM_ADDR_CON1, 8'h0c);
    sent.delete();
    nb = nbytes;
    for (int i = 0; i < 3; i++) begin
      sent.push_back(8'($random(seed)));
      wr(SPM_ADDR_TDR, sent[i]);
    end
    wait_bytes(nb + 3);
    for (int i = 0; i < 3; i++) `CHK(u_slv.got_q[nb + i], sent[i])
    `CHK(irq, 1'b1)
    rd_chk(SPM_ADDR_STAT, 8'h0f);
    `CHK(irq, 1'b0)
    rd_chk(SPM_ADDR_STAT, 8'h00);
    rd_chk(SPM_ADDR_RDR, reply(nb + 2));
    // fill the queue with transmit off, then drain unreceived
    wr(SPM_ADDR_CON1, 8'h00);
    wr(SPM_ADDR_CON0, 8'h18);
    sent.delete();
    nb = nbytes;
    for (int i = 0; i < 10; i++) begin
      sent.push_back(8'($random(seed)));
      wr(SPM_ADDR_TDR, sent[i]);
      @(negedge clk);
      `CHK(tx_room, (i < 8))
    end
    `CHK(nbytes, nb)
    wr(SPM_ADDR_CON0, 8'h58);
    wait_bytes(nb + 9);
    for (int i = 0; i < 9; i++) `CHK(u_slv.got_q[nb + i], sent[i])
    rd_chk(SPM_ADDR_STAT, 8'h0a);
    `CHK(nbytes, nb + 9)
    // abort in mid byte
    wr(SPM_ADDR_CON0, 8'h78);
    edges = 0;
    nb = nbytes;
    wr(SPM_ADDR_TDR, 8'h3c);
    for (int i = 0; i < 500 && edges < 3; i++) @(negedge clk);
    if (edges < 3) begin
      miscompares++;
      stop_test();
    end
    wr(SPM_ADDR_CON0, 8'h38);
    repeat (2) @(negedge clk);
    `CHK(sck, 1'b0)
    `CHK(sel_n, 1'b1)
    `CHK(nbytes, nb)
    // auto select off: byte runs, select stays high
    wr(SPM_ADDR_CON0, 8'h70);
    nb = nbytes;
    wr(SPM_ADDR_TDR, 8'hc3);
    repeat (120) begin
      @(negedge clk);
      `CHK(sel_n, 1'b1)
    end
    `CHK(sck, cpol)
    `CHK(nbytes, nb)
    rd_chk(SPM_ADDR_RDR, {8{sdi}});
    rd_chk(SPM_ADDR_STAT, 8'h0b);
    // processor reset in mid byte
    cpol = 1'b1;
    wr(SPM_ADDR_CON0, 8'h7a);
    nb = nbytes;
    wr(SPM_ADDR_TDR, 8'h5a);
    repeat (20) @(negedge clk);
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    `CHK(sck, 1'b0)
    `CHK(sel_n, 1'b1)
    rd_chk(SPM_ADDR_CON0, SPM_RST_CON0);
    rd_chk(SPM_ADDR_CLKD, SPM_RST_CLKD);
    rd_chk(SPM_ADDR_STAT, {4'h0, SPM_RST_FLAGS});
    `CHK(nbytes, nb)
    stop_test();
  end
endmodule
`default_nettype wire
